//--- common/ppm_pkg.sv
// Constants shared by the port pin override mux block
package ppm_pkg;
   localparam int          PIN_COUNT         = 8;
   // Register byte addresses on the AHB-Lite slave
   localparam logic [11:0] MISC_CTRL_ADDR    = 12'h000;
   localparam logic [11:0] PORT_LATCH_ADDR   = 12'h004;
   localparam logic [11:0] PORT_DIR_ADDR     = 12'h008;
   localparam logic [11:0] PORT_INPUT_ADDR   = 12'h00C;
   localparam logic [11:0] XMEM_CTRL_ADDR    = 12'h010;
   localparam logic [11:0] PCHG_MASK_ADDR    = 12'h014;
   // Field positions
   localparam int          PULLUP_OFF_BIT    = 2;
   localparam int          XMEM_ENABLE_BIT   = 0;
   localparam int          PCHG_GROUP_BIT    = 1;
   // Reset values
   localparam logic [7:0]  MISC_CTRL_RESET   = 8'h00;
   localparam logic [7:0]  PORT_REG_RESET    = 8'h00;
   localparam logic [1:0]  XMEM_CTRL_RESET   = 2'h0;
   // AHB codes
   localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ        = 2'h3;
   localparam logic [2:0]  HSIZE_WORD        = 3'h2;
endpackage

//--- src/ppm_pin_sync.sv
// Two-stage input synchroniser for the pin read path
`timescale 1ns/1ps
module ppm_pin_sync (
   input  wire logic       clk_sys_i,
   input  wire logic       reset_i,
   input  wire logic [7:0] pin_raw_i,
   output logic      [7:0] pin_sync_o
);
   logic [7:0] stage1_reg;

   // First stage is read only by the second stage
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         stage1_reg <= ppm_pkg::PORT_REG_RESET;
         pin_sync_o <= ppm_pkg::PORT_REG_RESET;
      end else begin
         stage1_reg <= pin_raw_i;
         pin_sync_o <= stage1_reg;
      end
   end
endmodule

//--- src/ppm_top.sv
// Port A pin override mux with AHB-Lite register slave
`timescale 1ns/1ps

// Overview of operation
// - Override enable selects pull-up value, else pull-up when dir/latch/off = 010
// - Pull-up override ignores direction and global off bits, but its value uses the latch bit
// - Direction override enable selects driver enable, else software direction bit
// - Direction override value one drives, zero releases, direction bit ignored
// - Driven level is override level when enabled, else output latch bit
// - Input buffer enable follows override value, else normal/sleep state
// - Function input taken unsynchronised; receivers synchronise unless used as clock
// - Global pull-up off bit 2 disables every pull-up not under override
// - Misc control register eight bits, all read/write, resets to zero
// - External memory enable overrides Port A pull-up, direction, value
// - Drive address in address phase else data gated by write strobe
// - Input override enable is group enable AND pin mask, value one
// - Pin input feeds bus data input and pin-change line; no analog link
// - No override: dir0 latch0 hi-Z, latch1 pull-up unless off bit 2 set, dir1 drives latch
// - Software pin reads pass a two-stage synchroniser on system clock
module ppm_top (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Processor sleep state
   input  wire logic        sleep_i,
   // External memory interface side
   input  wire logic        address_phase_i,
   input  wire logic        write_strobe_i,
   input  wire logic [7:0]  xmem_addr_low_i,
   input  wire logic [7:0]  xmem_data_out_i,
   output logic      [7:0]  xmem_data_in_o,
   // Pin-change controller side
   output logic      [7:0]  pin_change_line_o,
   // Pads
   input  wire logic [7:0]  pad_in_i,
   output logic      [7:0]  pad_out_o,
   output logic      [7:0]  pad_oe_o,
   output logic      [7:0]  pad_pullup_o,
   output logic      [7:0]  pad_input_enable_o,
   // Raw function input
   output logic      [7:0]  pin_input_to_function_o
);
   // Register state
   logic [7:0]  port_misc_control_reg;
   logic [7:0]  pin_output_latch_reg;
   logic [7:0]  pin_direction_reg;
   logic [7:0]  pin_change_mask_reg;
   logic [1:0]  xmem_ctrl_reg;
   logic [7:0]  pin_input_sync_bit;
   // Bus data phase state
   logic        wr_pending_reg;
   logic [11:0] wr_addr_reg;
   logic [31:0] hrdata_reg;
   logic        access_ok;
   logic [31:0] read_value;
   // Override signals
   logic        pullup_global_off;
   logic        external_memory_enable;
   logic        pin_change_group_enable;
   logic [7:0]  pullup_override_enable;
   logic [7:0]  pullup_override_value;
   logic [7:0]  dir_override_enable;
   logic [7:0]  dir_override_value;
   logic [7:0]  value_override_enable;
   logic [7:0]  value_override_level;
   logic [7:0]  input_enable_override_enable;
   logic [7:0]  input_enable_override_value;
   logic [7:0]  pin_input_to_function;

   // Register reads, unmapped offsets answer zero
   function automatic logic [31:0] reg_read(input logic [11:0] addr);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (addr)
         ppm_pkg::MISC_CTRL_ADDR:  v = {24'h00_0000, port_misc_control_reg};
         ppm_pkg::PORT_LATCH_ADDR: v = {24'h00_0000, pin_output_latch_reg};
         ppm_pkg::PORT_DIR_ADDR:   v = {24'h00_0000, pin_direction_reg};
         ppm_pkg::PORT_INPUT_ADDR: v = {24'h00_0000, pin_input_sync_bit};
         ppm_pkg::XMEM_CTRL_ADDR:  v = {30'h0000_0000, xmem_ctrl_reg};
         ppm_pkg::PCHG_MASK_ADDR:  v = {24'h00_0000, pin_change_mask_reg};
         default:                  v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Zero wait state slave, always OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_reg;
   assign access_ok   = hsel_i && hready_i && htrans_i[1];
   assign read_value  = reg_read(haddr_i[11:0]);

   // Address phase capture; read data loaded for the data phase
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         wr_pending_reg <= 1'b0;
         wr_addr_reg    <= 12'h000;
         hrdata_reg     <= 32'h0000_0000;
      end else begin
         wr_pending_reg <= access_ok && hwrite_i;
         if (access_ok) begin
            wr_addr_reg <= haddr_i[11:0];
         end
         if (access_ok && !hwrite_i) begin
            hrdata_reg <= read_value;
         end
      end
   end

   // Misc control register, every bit read/write
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         port_misc_control_reg <= ppm_pkg::MISC_CTRL_RESET;
      end else if (wr_pending_reg && wr_addr_reg == ppm_pkg::MISC_CTRL_ADDR) begin
         port_misc_control_reg <= hwdata_i[7:0];
      end
   end

   // Port latch, direction, mask and memory control registers
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         pin_output_latch_reg <= ppm_pkg::PORT_REG_RESET;
         pin_direction_reg    <= ppm_pkg::PORT_REG_RESET;
         pin_change_mask_reg  <= ppm_pkg::PORT_REG_RESET;
         xmem_ctrl_reg        <= ppm_pkg::XMEM_CTRL_RESET;
      end else if (wr_pending_reg) begin
         unique case (wr_addr_reg)
            ppm_pkg::PORT_LATCH_ADDR: pin_output_latch_reg <= hwdata_i[7:0];
            ppm_pkg::PORT_DIR_ADDR:   pin_direction_reg    <= hwdata_i[7:0];
            ppm_pkg::PCHG_MASK_ADDR:  pin_change_mask_reg  <= hwdata_i[7:0];
            ppm_pkg::XMEM_CTRL_ADDR:  xmem_ctrl_reg        <= hwdata_i[1:0];
            default: ;
         endcase
      end
   end

   assign pullup_global_off       = port_misc_control_reg[ppm_pkg::PULLUP_OFF_BIT];
   assign external_memory_enable  = xmem_ctrl_reg[ppm_pkg::XMEM_ENABLE_BIT];
   assign pin_change_group_enable = xmem_ctrl_reg[ppm_pkg::PCHG_GROUP_BIT];

   // Port A overrides from the external bus and pin-change logic
   always_comb begin
      for (int i = 0; i < ppm_pkg::PIN_COUNT; i++) begin
         pullup_override_enable[i] = external_memory_enable;
         dir_override_enable[i]    = external_memory_enable;
         value_override_enable[i]  = external_memory_enable;
         pullup_override_value[i]  = !(write_strobe_i || address_phase_i)
                                     && pin_output_latch_reg[i];
         dir_override_value[i]     = write_strobe_i || address_phase_i;
         value_override_level[i]   = address_phase_i ? xmem_addr_low_i[i]
                                     : (xmem_data_out_i[i] && write_strobe_i);
         input_enable_override_enable[i] = pin_change_group_enable
                                           && pin_change_mask_reg[i];
         input_enable_override_value[i]  = 1'b1;
      end
   end

   // Generic pin mux; combinational so the pad follows in the same cycle
   always_comb begin
      for (int i = 0; i < ppm_pkg::PIN_COUNT; i++) begin
         pad_pullup_o[i] = pullup_override_enable[i] ? pullup_override_value[i]
                           : (!pin_direction_reg[i] && pin_output_latch_reg[i]
                              && !pullup_global_off);
         pad_oe_o[i]     = dir_override_enable[i] ? dir_override_value[i]
                           : pin_direction_reg[i];
         pad_out_o[i]    = value_override_enable[i] ? value_override_level[i]
                           : pin_output_latch_reg[i];
         pad_input_enable_o[i] = input_enable_override_enable[i]
                                 ? input_enable_override_value[i]
                                 : !sleep_i;
         // Clamped input when the buffer is disabled
         pin_input_to_function[i] = pad_in_i[i] && pad_input_enable_o[i];
      end
   end

   // Function input is raw; receivers must synchronise it themselves
   assign pin_input_to_function_o = pin_input_to_function;
   assign xmem_data_in_o          = pin_input_to_function;
   assign pin_change_line_o       = pin_input_to_function;

   // Software read path through synchroniser
   ppm_pin_sync u_sync (
      .clk_sys_i  (clk_sys_i),
      .reset_i    (reset_i),
      .pin_raw_i  (pin_input_to_function),
      .pin_sync_o (pin_input_sync_bit)
   );

   // Port A has no analog link; pass-through not present on these pins
endmodule

//--- sim/ppm_top_sva.sv
// Port-level assertions for the pin override mux
`timescale 1ns/1ps
module ppm_top_sva (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hrdata_o,
   input  wire logic        hreadyout_o,
   input  wire logic        hresp_o,
   input  wire logic        sleep_i,
   input  wire logic [7:0]  pad_in_i,
   input  wire logic [7:0]  pad_oe_o,
   input  wire logic [7:0]  pad_pullup_o,
   input  wire logic [7:0]  pad_input_enable_o,
   input  wire logic [7:0]  pin_change_line_o,
   input  wire logic [7:0]  pin_input_to_function_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   // Read request taken this edge
   wire rd_w = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   a_bus_okay: assert property (!hresp_o && hreadyout_o) else $error("bus answer not OKAY");
   a_upper_zero: assert property (hrdata_o[31:8] == 24'h00_0000) else $error("upper read bits");
   a_func_gated: assert property (
      pin_input_to_function_o == (pad_in_i & pad_input_enable_o)) else $error("function input");
   a_pcint_feed: assert property (
      pin_change_line_o == pin_input_to_function_o) else $error("pin change line");
   a_awake_input: assert property (!sleep_i |-> &pad_input_enable_o) else $error("input off");
   a_no_pull_drive: assert property ((pad_oe_o & pad_pullup_o) == 8'h00) else $error("pull+drive");
   a_reset_quiet: assert property ($fell(reset_i) |-> !pad_oe_o && !pad_pullup_o)
      else $error("pads active after reset");
   // Stable pad for three samples must read back unchanged; fresh reset excluded
   a_sync_read: assert property (rd_w && haddr_i[11:0] == ppm_pkg::PORT_INPUT_ADDR
      && &pad_input_enable_o && $stable(pad_in_i) && $past($stable(pad_in_i))
      && !$past(reset_i) && !$past(reset_i, 2) |=> hrdata_o[7:0] == $past(pad_in_i))
      else $error("synchronised read");
   a_unmapped_zero: assert property (rd_w && haddr_i == 32'h0000_0018 |=> hrdata_o == 32'h0)
      else $error("unmapped read");
   c_read_data: cover property (rd_w ##1 hrdata_o[7:0] != 8'h00);
   c_sleep_kept: cover property (sleep_i && pad_input_enable_o != 8'h00);
   c_all_drive: cover property (pad_oe_o == 8'hff);
endmodule

//--- sim/ppm_pad_model.sv
// Pad-side model: external drivers, pull-ups and floating lines
`timescale 1ns/1ps
module ppm_pad_model (
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] pad_out_i,
   input  wire logic [7:0] pad_oe_i,
   input  wire logic [7:0] pad_pullup_i,
   input  wire logic       ext_en_i,
   input  wire logic [7:0] ext_val_i,
   output logic      [7:0] pad_o
);
   logic [7:0] float_q = 8'h5a;
   // Undriven lines wander so a stale level never passes for a real one
   always @(posedge clk_sys_i) float_q <= float_q + 8'h3b;
   // Own driver wins, then the outside driver, then the pull-up
   always_comb pad_o = (pad_oe_i & pad_out_i)
      | (~pad_oe_i & (ext_en_i ? ext_val_i : (pad_pullup_i | float_q)));
endmodule

//--- sim/ppm_top_tb.sv
// Self-checking bench for the pin override mux
`timescale 1ns/1ps
module ppm_top_tb;
   logic        clk_sys_i = 1'b0;
   logic        reset_i   = 1'b1;
   logic        hwrite = 1'b0, sleep = 1'b0, ada = 1'b0, wr = 1'b0, ext_en = 1'b0, hro, hrs;
   logic [1:0]  htrans = 2'h0, m_xc;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [7:0]  xa = 8'h00, xd = 8'h00, ext = 8'h00, pad, dout, oe, pu, ie, fn, pcl, xin;
   logic [7:0]  m_misc, m_lat, m_dir, m_mask, e_oe, e_out, e_pu, e_ie;
   int          bad_count = 0, checked = 0, seed = 32'h1b0f, i;
   always #2.5 clk_sys_i = ~clk_sys_i;
   ppm_top i_ppm_top (.clk_sys_i, .reset_i, .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(ppm_pkg::HSIZE_WORD), .hwdata_i(hwdata), .hready_i(hro),
      .hrdata_o(hrdata), .hreadyout_o(hro), .hresp_o(hrs), .sleep_i(sleep),
      .address_phase_i(ada), .write_strobe_i(wr), .xmem_addr_low_i(xa), .xmem_data_out_i(xd),
      .xmem_data_in_o(xin), .pin_change_line_o(pcl), .pad_in_i(pad), .pad_out_o(dout),
      .pad_oe_o(oe), .pad_pullup_o(pu), .pad_input_enable_o(ie), .pin_input_to_function_o(fn));
   ppm_pad_model i_ppm_pad_model (.clk_sys_i, .pad_out_i(dout), .pad_oe_i(oe),
      .pad_pullup_i(pu), .ext_en_i(ext_en), .ext_val_i(ext), .pad_o(pad));
   task automatic wrap_up;
      if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // Bounded wait for hready at a rising edge
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
         if (n > 50) begin
            bad_count++;
            wrap_up();
         end
      end while (hro !== 1'b1);
   endtask
   // One single word transfer; read data taken at the data-phase edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      htrans <= ppm_pkg::HTRANS_NONSEQ;
      haddr  <= {20'h0_0000, a};
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   // Pad outputs against the model, sampled mid-cycle
   task automatic check_pads;
      logic x, s;
      x = m_xc[ppm_pkg::XMEM_ENABLE_BIT];
      @(negedge clk_sys_i);
      s = wr | ada;
      e_oe = x ? {8{s}} : m_dir;
      e_out = x ? (ada ? xa : xd & {8{wr}}) : m_lat;
      e_pu = x ? (s ? 8'h00 : m_lat) : (~m_dir & m_lat & {8{~m_misc[ppm_pkg::PULLUP_OFF_BIT]}});
      e_ie = (m_mask & {8{m_xc[ppm_pkg::PCHG_GROUP_BIT]}}) | {8{~sleep}};
      chk("oe", e_oe, oe);
      chk("out", e_out & e_oe, dout & oe);
      chk("pullup", e_pu, pu);
      chk("in_en", e_ie, ie);
      chk("func", pad & e_ie, fn);
      chk("pchg", pad & e_ie, pcl);
      chk("xin", pad & e_ie, xin & e_ie);
      @(posedge clk_sys_i);
   endtask
   initial begin
      {m_misc, m_lat, m_dir, m_mask, m_xc} = '0;
      repeat (12) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      check_pads();
      bus(1'b0, ppm_pkg::MISC_CTRL_ADDR, 32'h0);
      chk("misc_rst", 32'h0, rd);
      bus(1'b1, 12'h018, 32'hffff_ffff);
      bus(1'b0, 12'h018, 32'h0);
      chk("unmapped", 32'h0, rd);
      for (i = 0; i < 60; i++) begin
         {m_misc, m_lat, m_dir, m_mask, m_xc} = 34'({$random(seed), $random(seed)});
         bus(1'b1, ppm_pkg::MISC_CTRL_ADDR, {24'h00_0000, m_misc});
         bus(1'b1, ppm_pkg::PORT_LATCH_ADDR, {24'h00_0000, m_lat});
         bus(1'b1, ppm_pkg::PORT_DIR_ADDR, {24'h00_0000, m_dir});
         bus(1'b1, ppm_pkg::XMEM_CTRL_ADDR, {30'h0, m_xc});
         bus(1'b1, ppm_pkg::PCHG_MASK_ADDR, {24'h00_0000, m_mask});
         {sleep, ada, wr, ext_en} <= 4'($random(seed));
         {xa, xd, ext} <= 24'($random(seed));
         check_pads();
         bus(1'b0, ppm_pkg::MISC_CTRL_ADDR, 32'h0);
         chk("misc", {24'h00_0000, m_misc}, rd);
         if (ext_en && &e_ie) begin
            repeat (3) @(posedge clk_sys_i);
            bus(1'b0, ppm_pkg::PORT_INPUT_ADDR, 32'h0);
            chk("pin_in", {24'h00_0000, (e_oe & e_out) | (~e_oe & ext)}, rd);
         end
      end
      // Second reset in mid-run
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      {m_misc, m_lat, m_dir, m_mask, m_xc} = '0;
      check_pads();
      bus(1'b0, ppm_pkg::MISC_CTRL_ADDR, 32'h0);
      chk("misc_rst2", 32'h0, rd);
      wrap_up();
   end
endmodule
bind ppm_top ppm_top_sva i_ppm_top_sva (.clk_sys_i, .reset_i, .hsel_i, .haddr_i, .htrans_i,
   .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .sleep_i, .pad_in_i, .pad_oe_o,
   .pad_pullup_o, .pad_input_enable_o, .pin_change_line_o, .pin_input_to_function_o);
